// ==== stpld_event_if.sv ====
// Valid/ready carrier for shift and storage events
`timescale 1ns/1ps
interface stpld_event_if
  import stpld_pkg::*;
();
  logic         valid;
  logic         ready;
  stpld_event_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== stpld_fifo.sv ====
// Event FIFO with valid/ready on both sides and synchronous flush
`timescale 1ns/1ps
module stpld_fifo
  import stpld_pkg::*;
#(
  parameter int WIDTH = EV_W,
  parameter int DEPTH = EV_FIFO_DEPTH
) (
  input  wire logic     clk_sys_i,
  input  wire logic     reset_i,
  input  wire logic     flush_i,
  stpld_event_if.snk    wr,
  stpld_event_if.src    rd
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign empty    = (wr_ptr_q == rd_ptr_q);
  assign full     = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign wr.ready = ~full & ~flush_i;
  assign rd.valid = ~empty & ~flush_i;
  assign rd.data  = mem[rd_ptr_q[AW-1:0]];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else if (flush_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule

// ==== stpld_host_model.sv ====
// Host pin driver and pulled-up drain load
`timescale 1ns/1ps
module stpld_host_model (
  input  wire logic [7:0] sink_oe_i,
  input  wire logic       clk_sys_i,
  input  wire logic       serial_ret_i,
  output logic            shift_clock_o,
  output logic            storage_clock_o,
  output logic            clear_n_o,
  output logic            serial_in_o,
  output logic            output_enable_n_o,
  output logic      [7:0] sink_level_o
);
  // Pull-up on each drain, low while sinking
  assign sink_level_o = ~sink_oe_i;

  // Next chained stage on the shared shift clock
  logic [7:0] down_q = 8'h00;

  always @(posedge shift_clock_o) begin
    down_q <= {down_q[6:0], serial_ret_i};
  end

  initial begin
    shift_clock_o     = 1'b0;
    storage_clock_o   = 1'b0;
    clear_n_o         = 1'b0;
    serial_in_o       = 1'b0;
    output_enable_n_o = 1'b1;
  end

  task automatic shift_bit(input logic b);
    @(posedge clk_sys_i);
    serial_in_o <= b;
    repeat (5) @(posedge clk_sys_i);
    shift_clock_o <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    shift_clock_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic latch();
    @(posedge clk_sys_i);
    storage_clock_o <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    storage_clock_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
  endtask

  // Shift high far below its least width
  task automatic glitch_shift();
    @(posedge clk_sys_i);
    shift_clock_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    shift_clock_o <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic set_oe(input logic v);
    @(posedge clk_sys_i);
    output_enable_n_o <= v;
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic set_clear(input logic v);
    @(posedge clk_sys_i);
    clear_n_o <= v;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule

// ==== stpld_pkg.sv ====
// Constants and types shared by the serial-to-parallel lamp driver files
package stpld_pkg;

  // ***********************************************************
  // Channel count and reset values
  // ***********************************************************
  localparam int          CHANNELS        = 8;
  localparam logic [7:0]  SHIFT_RESET     = 8'h00;
  localparam logic [7:0]  STORE_RESET     = 8'h00;
  localparam logic        SERIAL_OUT_RESET   = 1'b0;

  // ***********************************************************
  // Event word carried through the FIFO
  // ***********************************************************
  localparam int          EV_W            = 4;
  localparam int          EV_SHIFT_POS    = 3;
  localparam int          EV_DATA_POS     = 2;
  localparam int          EV_STORE_POS    = 1;
  localparam int          EV_FALL_POS     = 0;
  localparam int          EV_FIFO_DEPTH   = 16;

  // ***********************************************************
  // Pin synchroniser layout and reset values
  // ***********************************************************
  localparam int          PIN_W           = 5;
  localparam int          PIN_SHIFT_POS   = 4;
  localparam int          PIN_STORE_POS   = 3;
  localparam int          PIN_CLEAR_POS   = 2;
  localparam int          PIN_SER_POS     = 1;
  localparam int          PIN_OE_POS      = 0;
  localparam logic [4:0]  PIN_RESET       = 5'h01;
  localparam int          SYNC_STAGES     = 2;

  // ***********************************************************
  // Thermal shutdown thresholds in degrees Celsius
  // ***********************************************************
  localparam int          TEMP_W          = 9;
  localparam logic [8:0]  TSD_TRIP_C      = 9'h0af;
  localparam logic [8:0]  TSD_RELEASE_C   = 9'h0a0;

  // ***********************************************************
  // Pin timing limits and their cycle counts
  // ***********************************************************
  localparam int          CLK_PERIOD_PS   = 4000;
  localparam int          SHIFT_CLOCK_WH_NS      = 30;
  localparam int          SHIFT_CLOCK_WL_NS      = 30;
  localparam int          SER_SETUP_NS    = 15;
  localparam int          SER_HOLD_NS     = 15;
  localparam int          SER_PULSE_NS    = 40;
  localparam int          DRAIN_SETTLE_NS = 220;
  localparam int          SAMPLE_TOL      = 1;
  localparam int          CNT_W           = 8;

  localparam int SHIFT_CLOCK_WH_CYC  = (SHIFT_CLOCK_WH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SHIFT_CLOCK_WL_CYC  = (SHIFT_CLOCK_WL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SER_SU_CYC   = (SER_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SER_H_CYC    = (SER_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SER_PW_CYC   = (SER_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DRAIN_ST_CYC = (DRAIN_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hff;

  typedef logic [EV_W-1:0] stpld_event_t;

endpackage

// ==== stpld_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module stpld_sync
  import stpld_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ==== stpld_top.sv ====
// Serial-in parallel-out lamp driver core with storage register and sink outputs
//
// Functional notes
// - Eight-bit shift register feeds eight-bit storage.
// - Shift rise moves stages, captures serial input.
// - Storage rise copies shift register into storage.
// - Storage reaches outputs only while clear high.
// - Clear low zeroes shift and storage registers.
// - Output enable high forces all sinks off.
// - Output enable low passes storage to outputs.
// - Buffer bit one sinks, zero is off.
// - Serial output updates on shift falling edge.
// - Serial output lags input seven and half periods.
// - Sinks change at the loading storage edge.
// - Over-temperature forces all sinks off.
// - Sinks resume once temperature falls below release.
`timescale 1ns/1ps
module stpld_top
  import stpld_pkg::*;
#(
  parameter int N_CH       = CHANNELS,
  parameter int FIFO_DEPTH = EV_FIFO_DEPTH
) (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  input  wire logic              shift_clock_i,
  input  wire logic              storage_clock_i,
  input  wire logic              clear_n_i,
  input  wire logic              serial_in_i,
  input  wire logic              output_enable_n_i,
  input  wire logic [TEMP_W-1:0] junction_temp_i,
  input  wire logic [N_CH-1:0]   sink_outputs_i,
  output logic      [N_CH-1:0]   sink_outputs_o,
  output logic      [N_CH-1:0]   sink_outputs_oe_o,
  output logic                   serial_out_o,
  output logic                   thermal_shutdown_o,
  output logic                   event_dropped_o,
  output logic                   timing_violation_o,
  output logic                   drain_fault_o
);

  // ***********************************************************
  // Helper functions
  // ***********************************************************

  // Saturating counter step
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt);
    logic [CNT_W-1:0] nxt;
    nxt = cnt;
    if (cnt != CNT_MAX) begin
      nxt = cnt + 1'b1;
    end
    return nxt;
  endfunction

  // Measured width short of a least figure, allowing sampling slack
  function automatic logic too_short(input logic [CNT_W-1:0] cnt, input int min_cyc);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(min_cyc - SAMPLE_TOL);
    return (cnt < lim);
  endfunction

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic [N_CH-1:0]  drain_s;

  assign pins_raw = {shift_clock_i, storage_clock_i, clear_n_i, serial_in_i, output_enable_n_i};

  stpld_sync #(
    .WIDTH     (PIN_W),
    .RESET_VAL (PIN_RESET)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  stpld_sync #(
    .WIDTH     (N_CH),
    .RESET_VAL ({N_CH{1'b1}})
  ) u_drain_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (sink_outputs_i),
    .sync_o    (drain_s)
  );

  logic shift_lvl;
  logic store_lvl;
  logic clear_act;
  logic ser_lvl;
  logic oe_n_lvl;

  assign shift_lvl = pins_s[PIN_SHIFT_POS];
  assign store_lvl = pins_s[PIN_STORE_POS];
  assign clear_act = ~pins_s[PIN_CLEAR_POS];
  assign ser_lvl   = pins_s[PIN_SER_POS];
  assign oe_n_lvl  = pins_s[PIN_OE_POS];

  // ***********************************************************
  // Edge detection on synchronised pins
  // ***********************************************************
  logic shift_d1_q;
  logic store_d1_q;
  logic ser_d1_q;
  logic shift_rise;
  logic shift_fall;
  logic store_rise;
  logic ser_change;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_d1_q <= 1'b0;
      store_d1_q <= 1'b0;
      ser_d1_q   <= 1'b0;
    end else begin
      shift_d1_q <= shift_lvl;
      store_d1_q <= store_lvl;
      ser_d1_q   <= ser_lvl;
    end
  end

  assign shift_rise = shift_lvl & ~shift_d1_q;
  assign shift_fall = ~shift_lvl & shift_d1_q;
  assign store_rise = store_lvl & ~store_d1_q;
  assign ser_change = ser_lvl ^ ser_d1_q;

  // ***********************************************************
  // Event queue
  // ***********************************************************
  stpld_event_if ev_in ();
  stpld_event_if ev_out ();

  // One word per cycle keeps simultaneous edges in their true order
  always_comb begin
    ev_in.valid                   = (shift_rise | shift_fall | store_rise) & ~clear_act;
    ev_in.data                    = '0;
    ev_in.data[EV_SHIFT_POS]      = shift_rise;
    ev_in.data[EV_DATA_POS]       = ser_lvl;
    ev_in.data[EV_STORE_POS]      = store_rise;
    ev_in.data[EV_FALL_POS]       = shift_fall;
  end

  assign ev_out.ready = ~clear_act;

  stpld_fifo #(
    .WIDTH     (EV_W),
    .DEPTH     (FIFO_DEPTH)
  ) u_event_fifo (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .flush_i   (clear_act),
    .wr        (ev_in),
    .rd        (ev_out)
  );

  logic         ev_take;
  stpld_event_t ev_word;

  assign ev_take = ev_out.valid & ev_out.ready;
  assign ev_word = ev_out.data;

  // ***********************************************************
  // Shift register
  // ***********************************************************
  logic [N_CH-1:0] shift_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= N_CH'(SHIFT_RESET);
    end else if (clear_act) begin
      shift_q <= N_CH'(SHIFT_RESET);
    end else if (ev_take && ev_word[EV_SHIFT_POS]) begin
      shift_q <= {shift_q[N_CH-2:0], ev_word[EV_DATA_POS]};
    end
  end

  // ***********************************************************
  // Storage register
  // ***********************************************************
  logic [N_CH-1:0] store_q;

  // Storage takes the shift contents from before a coincident shift
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      store_q <= N_CH'(STORE_RESET);
    end else if (clear_act) begin
      store_q <= N_CH'(STORE_RESET);
    end else if (ev_take && ev_word[EV_STORE_POS]) begin
      store_q <= shift_q;
    end
  end

  // ***********************************************************
  // Cascade serial output
  // ***********************************************************
  logic serial_out_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      serial_out_q <= SERIAL_OUT_RESET;
    end else if (clear_act) begin
      serial_out_q <= SERIAL_OUT_RESET;
    end else if (ev_take && ev_word[EV_FALL_POS]) begin
      serial_out_q <= shift_q[N_CH-1];
    end
  end

  assign serial_out_o = serial_out_q;

  // ***********************************************************
  // Thermal shutdown with hysteresis
  // ***********************************************************
  logic tsd_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tsd_q <= 1'b0;
    end else if (junction_temp_i > TSD_TRIP_C) begin
      tsd_q <= 1'b1;
    end else if (junction_temp_i < TSD_RELEASE_C) begin
      tsd_q <= 1'b0;
    end
  end

  assign thermal_shutdown_o = tsd_q;

  // ***********************************************************
  // Output buffers and drain enables
  // ***********************************************************
  logic [N_CH-1:0] sink_oe_q;
  logic [N_CH-1:0] sink_val_q;
  logic            drive_ok;

  // Active-low enable, clear released, no thermal trip
  assign drive_ok = ~oe_n_lvl & ~clear_act & ~tsd_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sink_oe_q <= '0;
    end else if (drive_ok) begin
      sink_oe_q <= store_q;
    end else begin
      sink_oe_q <= '0;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sink_val_q <= '0;
    end else begin
      sink_val_q <= '0;
    end
  end

  assign sink_outputs_oe_o = sink_oe_q;
  assign sink_outputs_o    = sink_val_q;

  // ***********************************************************
  // Dropped events
  // ***********************************************************
  logic drop_q;
  logic drop_set;

  assign drop_set = ev_in.valid & ~ev_in.ready;

  // Set wins over clear
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      drop_q <= 1'b0;
    end else if (drop_set) begin
      drop_q <= 1'b1;
    end else if (clear_act) begin
      drop_q <= 1'b0;
    end
  end

  assign event_dropped_o = drop_q;

  // ***********************************************************
  // Pin timing monitor
  // ***********************************************************
  logic [CNT_W-1:0] shift_lvl_cnt_q;
  logic [CNT_W-1:0] ser_stable_cnt_q;
  logic [CNT_W-1:0] since_rise_cnt_q;
  logic             viol_q;
  logic             viol_set;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_lvl_cnt_q <= CNT_ZERO;
    end else if (shift_rise || shift_fall) begin
      shift_lvl_cnt_q <= CNT_ZERO;
    end else begin
      shift_lvl_cnt_q <= sat_inc(shift_lvl_cnt_q);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ser_stable_cnt_q <= CNT_MAX;
    end else if (ser_change) begin
      ser_stable_cnt_q <= CNT_ZERO;
    end else begin
      ser_stable_cnt_q <= sat_inc(ser_stable_cnt_q);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      since_rise_cnt_q <= CNT_MAX;
    end else if (shift_rise) begin
      since_rise_cnt_q <= CNT_ZERO;
    end else begin
      since_rise_cnt_q <= sat_inc(since_rise_cnt_q);
    end
  end

  always_comb begin
    viol_set = 1'b0;
    if (shift_fall && too_short(shift_lvl_cnt_q, SHIFT_CLOCK_WH_CYC)) begin
      viol_set = 1'b1;
    end
    if (shift_rise && too_short(shift_lvl_cnt_q, SHIFT_CLOCK_WL_CYC)) begin
      viol_set = 1'b1;
    end
    if (shift_rise && too_short(ser_stable_cnt_q, SER_SU_CYC)) begin
      viol_set = 1'b1;
    end
    if (ser_change && too_short(since_rise_cnt_q, SER_H_CYC)) begin
      viol_set = 1'b1;
    end
    if (ser_change && too_short(ser_stable_cnt_q, SER_PW_CYC)) begin
      viol_set = 1'b1;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      viol_q <= 1'b0;
    end else if (viol_set) begin
      viol_q <= 1'b1;
    end else if (clear_act) begin
      viol_q <= 1'b0;
    end
  end

  assign timing_violation_o = viol_q;

  // ***********************************************************
  // Drain feedback check
  // ***********************************************************
  logic [N_CH-1:0]  oe_d1_q;
  logic [CNT_W-1:0] settle_cnt_q;
  logic             settled;
  logic             fault_q;
  logic             fault_set;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      oe_d1_q <= '0;
    end else begin
      oe_d1_q <= sink_oe_q;
    end
  end

  // Any enable change restarts the settling wait
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      settle_cnt_q <= CNT_ZERO;
    end else if (oe_d1_q != sink_oe_q) begin
      settle_cnt_q <= CNT_ZERO;
    end else begin
      settle_cnt_q <= sat_inc(settle_cnt_q);
    end
  end

  assign settled   = (settle_cnt_q >= CNT_W'(DRAIN_ST_CYC));
  assign fault_set = settled && ((sink_oe_q & drain_s) != '0);

  // Set wins over clear
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;
    end else if (clear_act) begin
      fault_q <= 1'b0;
    end
  end

  assign drain_fault_o = fault_q;

endmodule

// ==== stpld_top_assertions.sv ====
// Port-level checks of the lamp driver top
`timescale 1ns/1ps
module stpld_top_assertions
  import stpld_pkg::*;
#(
  parameter int N_CH       = CHANNELS,
  parameter int FIFO_DEPTH = EV_FIFO_DEPTH
) (
  input wire logic              clk_sys_i,
  input wire logic              reset_i,
  input wire logic              shift_clock_i,
  input wire logic              storage_clock_i,
  input wire logic              clear_n_i,
  input wire logic              serial_in_i,
  input wire logic              output_enable_n_i,
  input wire logic [TEMP_W-1:0] junction_temp_i,
  input wire logic [N_CH-1:0]   sink_outputs_i,
  input wire logic [N_CH-1:0]   sink_outputs_o,
  input wire logic [N_CH-1:0]   sink_outputs_oe_o,
  input wire logic              serial_out_o,
  input wire logic              thermal_shutdown_o,
  input wire logic              event_dropped_o,
  input wire logic              timing_violation_o,
  input wire logic              drain_fault_o
);
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  // ****************************************
  // Properties
  // ****************************************
  property p_clear_zero;
    !clear_n_i [*6] |-> sink_outputs_oe_o == '0 && !serial_out_o;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("outputs not cleared by clear");
  property p_oe_off;
    output_enable_n_i [*6] |-> sink_outputs_oe_o == '0;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("sinks on with enable high");
  property p_trip;
    junction_temp_i > TSD_TRIP_C |=> thermal_shutdown_o;
  endproperty
  a_trip: assert property (p_trip)
    else $error("no shutdown above trip");
  property p_release;
    junction_temp_i < TSD_RELEASE_C |=> !thermal_shutdown_o;
  endproperty
  a_release: assert property (p_release)
    else $error("shutdown held below release");
  property p_tsd_off;
    thermal_shutdown_o |=> sink_outputs_oe_o == '0;
  endproperty
  a_tsd_off: assert property (p_tsd_off)
    else $error("sinks on during shutdown");
  property p_only_store;
    (!output_enable_n_i && clear_n_i && $stable(storage_clock_i) && !thermal_shutdown_o) [*8]
      |=> $stable(sink_outputs_oe_o);
  endproperty
  a_only_store: assert property (p_only_store)
    else $error("sinks changed without storage edge");
  property p_ser_edge;
    $changed(serial_out_o) && clear_n_i |-> !shift_clock_i;
  endproperty
  a_ser_edge: assert property (p_ser_edge)
    else $error("serial out moved outside falling edge");
  property p_drive_low;
    sink_outputs_o == '0;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("drain driven high");

  c_load: cover property ($rose(storage_clock_i) ##6 sink_outputs_oe_o != '0);
  c_trip: cover property ($rose(thermal_shutdown_o));
  c_ser: cover property ($rose(serial_out_o));
endmodule

bind stpld_top stpld_top_assertions #(.N_CH(N_CH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_sys_i, .reset_i, .shift_clock_i, .storage_clock_i, .clear_n_i, .serial_in_i,
  .output_enable_n_i, .junction_temp_i, .sink_outputs_i, .sink_outputs_o,
  .sink_outputs_oe_o, .serial_out_o, .thermal_shutdown_o, .event_dropped_o,
  .timing_violation_o, .drain_fault_o);

// ==== tb_serial_to_parallel_lamp_driver.sv ====
// Self-checking bench for the lamp driver top
`timescale 1ns/1ps
module tb_serial_to_parallel_lamp_driver;
  import stpld_pkg::*;
  typedef struct {
    int         kind;
    logic [7:0] val;
  } stpld_note_t;

  logic              clk_sys_i;
  logic              reset_i;
  logic [TEMP_W-1:0] junction_temp;
  wire               shift_clk, store_clk, clear_n, serial_in, oe_n;
  wire  [7:0]        sink_lvl;
  wire  [7:0]        host_lvl;
  logic [7:0]        fault_inj   = 8'h00;
  logic [7:0]        sink_val, sink_oe;
  logic              serial_out, tsd, dropped, tviol, dfault;
  stpld_note_t       notes[$];
  int                miscompares = 0;
  int                checks_done = 0;
  int                wait_cnt    = 0;
  logic [7:0]        prev        = 8'h00;
  string             names[5]    = '{"sink enables", "serial out", "shutdown", "flags",
                                     "cascade stage"};

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  stpld_top DUT (
    .clk_sys_i, .reset_i, .shift_clock_i(shift_clk), .storage_clock_i(store_clk),
    .clear_n_i(clear_n), .serial_in_i(serial_in), .output_enable_n_i(oe_n),
    .junction_temp_i(junction_temp), .sink_outputs_i(sink_lvl), .sink_outputs_o(sink_val),
    .sink_outputs_oe_o(sink_oe), .serial_out_o(serial_out), .thermal_shutdown_o(tsd),
    .event_dropped_o(dropped), .timing_violation_o(tviol), .drain_fault_o(dfault));

  stpld_host_model u_host (
    .sink_oe_i(sink_oe), .clk_sys_i, .serial_ret_i(serial_out), .shift_clock_o(shift_clk),
    .storage_clock_o(store_clk), .clear_n_o(clear_n), .serial_in_o(serial_in),
    .output_enable_n_o(oe_n), .sink_level_o(host_lvl));

  // Injected drain faults hold a pin high against its sink
  assign sink_lvl = host_lvl | fault_inj;

  // ****************************************
  // Result monitor
  // ****************************************
  function automatic logic [7:0] observe(input int k);
    case (k)
      0: return sink_oe;
      1: return {7'h00, serial_out};
      2: return {7'h00, tsd};
      4: return u_host.down_q;
      default: return {5'h00, dropped, tviol, dfault};
    endcase
  endfunction

  always @(negedge clk_sys_i) begin
    if (notes.size() != 0) begin
      if (observe(notes[0].kind) === notes[0].val) begin
        checks_done++;
        wait_cnt = 0;
        void'(notes.pop_front());
      end else if (++wait_cnt > 20) begin
        $display("unexpected %s expected %h seen %h", names[notes[0].kind], notes[0].val,
                 observe(notes[0].kind));
        miscompares++;
        checks_done++;
        wait_cnt = 0;
        void'(notes.pop_front());
      end
    end
  end

  // ****************************************
  // Driver tasks
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic expect_val(input int k, input logic [7:0] v);
    int n;
    n = 0;
    notes.push_back('{k, v});
    while (notes.size() != 0 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (notes.size() != 0) begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic set_temp(input logic [TEMP_W-1:0] t);
    @(posedge clk_sys_i);
    junction_temp <= t;
    repeat (6) @(posedge clk_sys_i);
  endtask

  task automatic send_check(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      u_host.shift_bit(b[i]);
      if (i == 1) expect_val(1, {7'h00, prev[0]});
    end
    expect_val(0, prev);
    expect_val(4, prev);
    expect_val(1, {7'h00, b[7]});
    u_host.latch();
    expect_val(0, b);
    prev = b;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_i       = 1'b1;
    void'($urandom(32'he1a89a14));
    junction_temp = 9'($urandom % 160);
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    expect_val(0, 8'h00);
    u_host.set_clear(1'b1);
    u_host.set_oe(1'b0);
    send_check(8'h80);
    send_check(8'h01);
    repeat (4) send_check(8'($urandom));
    u_host.set_oe(1'b1);
    expect_val(0, 8'h00);
    u_host.set_oe(1'b0);
    expect_val(0, prev);
    set_temp(9'h0af);
    expect_val(2, 8'h00);
    set_temp(9'h0b0);
    expect_val(2, 8'h01);
    expect_val(0, 8'h00);
    set_temp(9'h0a0);
    expect_val(2, 8'h01);
    set_temp(9'h09f);
    expect_val(2, 8'h00);
    expect_val(0, prev);
    send_check(8'hff);
    // Stuck-high drain and a short shift pulse set both sticky flags
    fault_inj <= 8'h10;
    repeat (60) @(posedge clk_sys_i);
    u_host.glitch_shift();
    expect_val(3, 8'h03);
    fault_inj <= 8'h00;
    u_host.set_clear(1'b0);
    expect_val(0, 8'h00);
    expect_val(1, 8'h00);
    // Edges while cleared must be ignored
    u_host.shift_bit(1'b1);
    u_host.latch();
    u_host.set_clear(1'b1);
    u_host.latch();
    expect_val(0, 8'h00);
    expect_val(3, 8'h00);
    wrap_up();
  end
endmodule
